// >>> hdl/pmaf_top.sv
// Per-second availability filters, delay path and quarter-hour count
`timescale 1ns/1ps
`default_nettype none
`include "pmaf_map.svh"
module pmaf_top (
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Monitoring time base, pulses from on-chip logic on clk
    input  wire logic                        one_second_tick,
    input  wire logic                        quarter_hour_tick,
    // Per-direction events, index 0 is A/Z and 1 is Z/A
    input  wire pmaf_pkg::pmaf_events_s [1:0] events_in,
    // Which event inputs are wired up in each direction
    input  wire pmaf_pkg::pmaf_conn_s   [1:0] events_connected,
    // Signal outside availability processing
    input  wire logic [`PMAF_PTR_W-1:0]      pointer_justify_event,
    // Unidirectional filter results per direction
    output var  pmaf_pkg::pmaf_events_s [1:0] unidir_events,
    output var  logic [1:0]                  unidir_unavail_second_flag,
    output var  logic [1:0]                  unavail_time_command,
    output var  logic [1:0]                  unidir_report,
    // Bidirectional filter results
    output var  pmaf_pkg::pmaf_events_s [1:0] bidir_events,
    output var  logic                        bidir_unavail_second_flag,
    output var  logic                        unavail_time_combined,
    output var  logic                        bidir_report,
    // Delayed non-availability signal
    output var  logic [`PMAF_PTR_W-1:0]      pointer_justify_delayed,
    // Quarter-hour count of bidirectional unavailable seconds
    output var  logic [`PMAF_ACC_W-1:0]      current_quarter_count,
    output var  logic [`PMAF_ACC_W-1:0]      history_count,
    output var  logic                        history_valid
);
    localparam int LAST = `PMAF_DELAY_SECS - 1;  // Oldest tap

    // Event delay line; tap LAST holds the value of ten seconds ago
    pmaf_pkg::pmaf_events_s [1:0] ev_dly [0:LAST];
    // Command history for the combined decision
    logic [1:0]                   cmd_dly [0:LAST];
    // Plain delay path
    logic [`PMAF_PTR_W-1:0]       ptr_dly [0:LAST];

    wire pmaf_pkg::pmaf_events_s [1:0] ev_clean;      // Gated inputs
    wire pmaf_pkg::pmaf_events_s [1:0] next_unidir;   // Unidirectional result
    wire pmaf_pkg::pmaf_events_s [1:0] next_bidir;    // Bidirectional result
    wire  [1:0]                   cmd;           // Per-direction command
    wire  [1:0]                   cmd_chg;       // Command change pulses
    wire                          next_combined; // OR of late commands
    wire  [`PMAF_ACC_W-1:0]       acc_in;        // Count input

    // Absent inputs contribute nothing, even if the wire floats high
    genvar d;
    generate
        for (d = 0; d < 2; d++) begin : g_dir
            assign ev_clean[d].background_block_err =
                events_connected[d].background_block_err
                ? events_in[d].background_block_err : '0;
            assign ev_clean[d].errored_sec =
                events_connected[d].errored_sec
                && events_in[d].errored_sec;
            assign ev_clean[d].severe_errored_sec =
                events_connected[d].severe_errored_sec
                && events_in[d].severe_errored_sec;
            // Late values pass only in available time
            assign next_unidir[d] = cmd[d] ? '0 : ev_dly[LAST][d];
            assign next_bidir[d]  = next_combined
                                  ? '0 : ev_dly[LAST][d];

            pmaf_unavail_eval u_eval (
                .clk                (clk),
                .rst                (rst),
                .one_second_tick    (one_second_tick),
                .severe_errored_sec (ev_clean[d].severe_errored_sec),
                .unavail_time_cmd   (cmd[d]),
                .cmd_changed        (cmd_chg[d])
            );
        end
    endgenerate

    // Unavailable if either direction was, as of ten seconds ago
    assign next_combined = |cmd_dly[LAST];
    // Each unavailable second counts one in the current register
    assign acc_in = {{(`PMAF_ACC_W-1){1'b0}}, next_combined};

    // Delay lines shift only on the second tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i <= LAST; i++) begin
                ev_dly[i]  <= '0;
                cmd_dly[i] <= '0;
                ptr_dly[i] <= '0;
            end
        end else if (one_second_tick) begin
            ev_dly[0]  <= ev_clean;
            cmd_dly[0] <= cmd;
            ptr_dly[0] <= pointer_justify_event;
            for (int i = 1; i <= LAST; i++) begin
                ev_dly[i]  <= ev_dly[i-1];
                cmd_dly[i] <= cmd_dly[i-1];
                ptr_dly[i] <= ptr_dly[i-1];
            end
        end
    end

    // Filter outputs refresh once per second and hold in between
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unidir_events              <= '0;
            unidir_unavail_second_flag <= '0;
            bidir_events               <= '0;
            bidir_unavail_second_flag  <= 1'b0;
            unavail_time_combined      <= 1'b0;
            pointer_justify_delayed    <= '0;
        end else if (one_second_tick) begin
            unidir_events              <= next_unidir;
            unidir_unavail_second_flag <= cmd;
            bidir_events               <= next_bidir;
            bidir_unavail_second_flag  <= next_combined;
            unavail_time_combined      <= next_combined;
            pointer_justify_delayed    <= ptr_dly[LAST];
        end
    end

    // Command copies and report pulses; every change is one pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            unavail_time_command <= '0;
            unidir_report        <= '0;
            bidir_report         <= 1'b0;
        end else begin
            unavail_time_command <= cmd;
            unidir_report        <= cmd_chg;
            bidir_report         <= one_second_tick
                && (next_combined != unavail_time_combined);
        end
    end

    // Current register; 32 bits exceed any interval's nominal count
    pmaf_accum u_accum (
        .clk                   (clk),
        .rst                   (rst),
        .one_second_tick       (one_second_tick),
        .quarter_hour_tick     (quarter_hour_tick),
        .accum_input           (acc_in),
        .current_quarter_count (current_quarter_count),
        .history_count         (history_count),
        .history_valid         (history_valid)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Unidirectional checks use the command as seen by the filter at the tick
    uni_zero_a: assert property (
        one_second_tick && cmd[0] |=> unidir_events[0] == '0)
        else $error("unidirectional values passed in unavailable time");
    uni_pass_a: assert property (
        one_second_tick && !cmd[1]
        |=> unidir_events[1] == $past(ev_dly[LAST][1]))
        else $error("unidirectional values not passed when available");
    uni_flag_a: assert property (
        one_second_tick |=> unidir_unavail_second_flag == $past(cmd))
        else $error("unidirectional unavailable flag wrong");
    bidir_or_a: assert property (
        one_second_tick |=> unavail_time_combined
            == $past(cmd_dly[LAST][0] || cmd_dly[LAST][1]))
        else $error("combined state is not the late OR of commands");
    bidir_zero_a: assert property (
        unavail_time_combined |-> bidir_events == '0)
        else $error("bidirectional values passed in unavailable time");
    bidir_flag_a: assert property (
        bidir_unavail_second_flag == unavail_time_combined)
        else $error("bidirectional unavailable flag wrong");
    bidir_report_a: assert property (
        $changed(unavail_time_combined) |-> $past(1'b1) && bidir_report)
        else $error("combined state change not reported");
    conn_gate_a: assert property (
        !events_connected[0].severe_errored_sec
        |-> !ev_clean[0].severe_errored_sec)
        else $error("unconnected severe input not held at zero");
    hold_idle_a: assert property (
        !one_second_tick |=> $stable(pointer_justify_delayed)
            && $stable(bidir_events))
        else $error("outputs moved without a second tick");

    uni_unavail_c: cover property (unidir_unavail_second_flag[0]);
    bidir_unavail_c: cover property (
        !unavail_time_combined ##1 unavail_time_combined);
    bidir_back_c: cover property (
        unavail_time_combined ##1 !unavail_time_combined);
endmodule : pmaf_top
`default_nettype wire

// >>> hdl/pmaf_map.svh
// Constants of the per-second availability filter and quarter-hour counter
`ifndef PMAF_MAP_SVH
`define PMAF_MAP_SVH

`define PMAF_BLK_ERR_W  16
`define PMAF_PTR_W      16
`define PMAF_ACC_W      32
`define PMAF_DELAY_SECS 10
`define PMAF_RUN_SECS   4'hA
`define PMAF_CNT_W      4
`define PMAF_ACC_MAX    32'hFFFF_FFFF
`define PMAF_ACC_RST    32'h0000_0000

`endif

// >>> hdl/pmaf_pkg.sv
// Types shared by the availability filter files
`default_nettype none
`include "pmaf_map.svh"
package pmaf_pkg;
    // One second of error classification for one direction
    typedef struct packed {
        logic [`PMAF_BLK_ERR_W-1:0] background_block_err;
        logic                       errored_sec;
        logic                       severe_errored_sec;
    } pmaf_events_s;

    // Input presence flags, one per event kind
    typedef struct packed {
        logic background_block_err;
        logic errored_sec;
        logic severe_errored_sec;
    } pmaf_conn_s;
endpackage : pmaf_pkg
`default_nettype wire

// >>> hdl/pmaf_uat_eval.sv
// Unavailable-time command evaluation for one direction
`timescale 1ns/1ps
`default_nettype none
`include "pmaf_map.svh"
module pmaf_unavail_eval (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic one_second_tick,
    input  wire logic severe_errored_sec,
    output var  logic unavail_time_cmd,
    output var  logic cmd_changed
);
    logic [`PMAF_CNT_W-1:0] run;       // Length of current opposing run
    wire  [`PMAF_CNT_W-1:0] run_inc;   // Run after this second
    wire                    opposing;  // Second argues for a state change
    wire                    flip;      // Tenth opposing second reached

    // A severe second opposes available time, a clean one opposes
    // unavailable time
    assign opposing = unavail_time_cmd ? !severe_errored_sec
                                       : severe_errored_sec;
    assign run_inc  = run + `PMAF_CNT_W'(1);
    assign flip     = opposing && (run_inc == `PMAF_RUN_SECS);

    // Run counter and command, stepped once per second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run              <= '0;
            unavail_time_cmd <= 1'b0;
            cmd_changed      <= 1'b0;
        end else begin
            cmd_changed <= one_second_tick && flip;
            if (one_second_tick) begin
                // Any non-opposing second breaks the run
                run <= (opposing && !flip) ? run_inc : '0;
                if (flip) begin
                    unavail_time_cmd <= !unavail_time_cmd;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cmd_set_a: assert property (
        one_second_tick && !unavail_time_cmd && severe_errored_sec
        && run == `PMAF_CNT_W'(9) |=> unavail_time_cmd && cmd_changed)
        else $error("command not set after ten severe seconds");
    cmd_clear_a: assert property (
        one_second_tick && unavail_time_cmd && !severe_errored_sec
        && run == `PMAF_CNT_W'(9) |=> !unavail_time_cmd)
        else $error("command not cleared after ten clean seconds");
    cmd_early_a: assert property (
        one_second_tick && !unavail_time_cmd && run < `PMAF_CNT_W'(9)
        |=> !unavail_time_cmd)
        else $error("command set before ten severe seconds");
    cmd_report_a: assert property (
        $changed(unavail_time_cmd) |-> cmd_changed)
        else $error("command change not reported");
    cmd_set_c: cover property (
        !unavail_time_cmd ##1 unavail_time_cmd);
endmodule : pmaf_unavail_eval
`default_nettype wire

// >>> hdl/pmaf_accum.sv
// Saturating quarter-hour current register with hand-over
`timescale 1ns/1ps
`default_nettype none
`include "pmaf_map.svh"
module pmaf_accum (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   one_second_tick,
    input  wire logic                   quarter_hour_tick,
    input  wire logic [`PMAF_ACC_W-1:0] accum_input,
    output var  logic [`PMAF_ACC_W-1:0] current_quarter_count,
    output var  logic [`PMAF_ACC_W-1:0] history_count,
    output var  logic                   history_valid
);
    // Add with a ceiling so the count never wraps to a small value
    function automatic logic [`PMAF_ACC_W-1:0] sat_add(
        input logic [`PMAF_ACC_W-1:0] a,
        input logic [`PMAF_ACC_W-1:0] b);
        logic [`PMAF_ACC_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[`PMAF_ACC_W] ? `PMAF_ACC_MAX : s[`PMAF_ACC_W-1:0];
    endfunction : sat_add

    wire [`PMAF_ACC_W-1:0] step;   // Input seen this cycle
    wire [`PMAF_ACC_W-1:0] summed; // Count including this second

    assign step   = one_second_tick ? accum_input : '0;
    assign summed = sat_add(current_quarter_count, step);

    // A coinciding last second goes into the handed-over total
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            current_quarter_count <= `PMAF_ACC_RST;
            history_count         <= `PMAF_ACC_RST;
            history_valid         <= 1'b0;
        end else begin
            history_valid <= quarter_hour_tick;
            if (quarter_hour_tick) begin
                history_count         <= summed;
                current_quarter_count <= `PMAF_ACC_RST;
            end else begin
                current_quarter_count <= summed;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    acc_sat_a: assert property (
        current_quarter_count == `PMAF_ACC_MAX && !quarter_hour_tick
        |=> current_quarter_count == `PMAF_ACC_MAX)
        else $error("current register left its maximum");
    acc_restart_a: assert property (
        quarter_hour_tick |=> current_quarter_count == '0 && history_valid)
        else $error("current register not restarted at interval end");
    acc_add_a: assert property (
        !quarter_hour_tick && !one_second_tick
        |=> $stable(current_quarter_count))
        else $error("current register moved without a second tick");
    acc_hand_c: cover property (
        current_quarter_count != '0 ##1 quarter_hour_tick);
endmodule : pmaf_accum
`default_nettype wire

// >>> testbench/pmaf_src_model.sv
// Upstream error-second source that drives the monitoring time base
`timescale 1ns/1ps
`default_nettype none
`include "pmaf_map.svh"
module pmaf_src_model (
    input  wire logic                        clk,
    output var  logic                        one_second_tick,
    output var  logic                        quarter_hour_tick,
    output var  pmaf_pkg::pmaf_events_s [1:0] events_in,
    output var  logic [`PMAF_PTR_W-1:0]      pointer_justify_event
);
    // Quiet time base until the first second is sent
    initial begin
        one_second_tick       = 1'b0;
        quarter_hour_tick     = 1'b0;
        events_in             = '0;
        pointer_justify_event = 16'h0000;
    end

    // One second: tick for one clock, then three idle clocks.
    // Between ticks the data shows its inverse, so a filter that
    // samples off the tick picks up wrong values and is caught.
    task automatic second(
        input pmaf_pkg::pmaf_events_s [1:0] ev,
        input logic [`PMAF_PTR_W-1:0]      ptr_ev,
        input logic                        q);
        @(posedge clk);
        one_second_tick       <= 1'b1;
        quarter_hour_tick     <= q;
        events_in             <= ev;
        pointer_justify_event <= ptr_ev;
        @(posedge clk);
        one_second_tick       <= 1'b0;
        quarter_hour_tick     <= 1'b0;
        events_in             <= ~ev;
        pointer_justify_event <= ~ptr_ev;
        @(posedge clk);
        @(posedge clk);
    endtask : second
endmodule : pmaf_src_model
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the availability filters and quarter count
`timescale 1ns/1ps
`default_nettype none
`include "pmaf_map.svh"
module tb;
    // Both directions of one second travel as one packed pair
    typedef pmaf_pkg::pmaf_events_s [1:0] pmaf_pair_t;

    logic                       clk;
    logic                       rst;
    logic                       one_second_tick;
    logic                       quarter_hour_tick;
    pmaf_pair_t                 events_in;
    pmaf_pkg::pmaf_conn_s [1:0] events_connected;
    logic [`PMAF_PTR_W-1:0]     pointer_justify_event;
    pmaf_pair_t                 unidir_events;
    logic [1:0]                 unidir_unavail_second_flag;
    logic [1:0]                 unavail_time_command;
    logic [1:0]                 unidir_report;
    pmaf_pair_t                 bidir_events;
    logic                       bidir_unavail_second_flag;
    logic                       unavail_time_combined;
    logic                       bidir_report;
    logic [`PMAF_PTR_W-1:0]     pointer_justify_delayed;
    logic [`PMAF_ACC_W-1:0]     current_quarter_count;
    logic [`PMAF_ACC_W-1:0]     history_count;
    logic                       history_valid;
    int                         n_mismatch = 0;
    int                         comparisons = 0;
    // Reference: delay lines, command history, runs and counts
    pmaf_pair_t                 dq [10] = '{default: '0};
    logic [`PMAF_PTR_W-1:0]     pq [10] = '{default: '0};
    logic [1:0]                 ch [10] = '{default: '0};
    logic [1:0]                 cmd = 2'h0;
    int                         run [2] = '{0, 0};
    logic                       comb = 1'b0;
    logic [`PMAF_ACC_W-1:0]     acc = 32'h0000_0000;
    logic [`PMAF_ACC_W-1:0]     hist;
    int e_rep0 = 0, e_rep1 = 0, e_brep = 0, e_hv = 0;
    int n_rep0 = 0, n_rep1 = 0, n_brep = 0, n_hv = 0;

    pmaf_top i_pmaf_top (.clk(clk), .rst(rst),
        .one_second_tick(one_second_tick),
        .quarter_hour_tick(quarter_hour_tick), .events_in(events_in),
        .events_connected(events_connected),
        .pointer_justify_event(pointer_justify_event),
        .unidir_events(unidir_events),
        .unidir_unavail_second_flag(unidir_unavail_second_flag),
        .unavail_time_command(unavail_time_command),
        .unidir_report(unidir_report), .bidir_events(bidir_events),
        .bidir_unavail_second_flag(bidir_unavail_second_flag),
        .unavail_time_combined(unavail_time_combined),
        .bidir_report(bidir_report),
        .pointer_justify_delayed(pointer_justify_delayed),
        .current_quarter_count(current_quarter_count),
        .history_count(history_count), .history_valid(history_valid));

    pmaf_src_model i_pmaf_src_model (.clk(clk),
        .one_second_tick(one_second_tick),
        .quarter_hour_tick(quarter_hour_tick), .events_in(events_in),
        .pointer_justify_event(pointer_justify_event));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pulse counters; pulses are only one clock wide
    always @(posedge clk) begin
        if (rst === 1'b0) begin
            if (unidir_report[0] === 1'b1) n_rep0++;
            if (unidir_report[1] === 1'b1) n_rep1++;
            if (bidir_report === 1'b1) n_brep++;
            if (history_valid === 1'b1) n_hv++;
        end
    end

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        comparisons++;
        if (e !== g) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Direction 0 gets b, direction 1 its inverse; errored flag is b[0] (dir 0) or b[1] (dir 1), or severe
    function automatic pmaf_pair_t mk(input logic [15:0] b,
                                      input logic s0, input logic s1);
        mk[0] = {b, b[0] | s0, s0};
        mk[1] = {~b, b[1] | s1, s1};
    endfunction : mk

    // One second: advance the reference, send it, compare outputs
    task automatic sec(input pmaf_pair_t ev, input logic [15:0] ptr_ev,
                       input logic q);
        pmaf_pair_t  g, d, ue, be;
        logic [1:0]  old;
        logic        nc;
        logic [15:0] ptr_exp;
        for (int i = 0; i < 2; i++) begin
            g[i] = ev[i] & {
                {16{events_connected[i].background_block_err}},
                events_connected[i].errored_sec,
                events_connected[i].severe_errored_sec};
        end
        d = dq[9];
        ptr_exp = pq[9];
        old = cmd;
        nc = ch[9][0] | ch[9][1];
        for (int k = 9; k > 0; k--) begin
            dq[k] = dq[k-1];
            pq[k] = pq[k-1];
            ch[k] = ch[k-1];
        end
        dq[0] = g;
        pq[0] = ptr_ev;
        ch[0] = old;
        for (int i = 0; i < 2; i++) begin
            run[i] = (g[i].severe_errored_sec != cmd[i]) ? run[i] + 1 : 0;
            ue[i] = old[i] ? '0 : d[i];
            if (run[i] == 10) begin
                cmd[i] = ~cmd[i];
                run[i] = 0;
            end
        end
        e_rep0 += int'(cmd[0] ^ old[0]);
        e_rep1 += int'(cmd[1] ^ old[1]);
        e_brep += int'(nc ^ comb);
        comb = nc;
        be = comb ? '0 : d;
        hist = acc + comb;
        acc = q ? 32'h0000_0000 : hist;
        e_hv += int'(q);
        i_pmaf_src_model.second(ev, ptr_ev, q);
        chk("unidir_events", ue, unidir_events);
        chk("unidir_flag", old, unidir_unavail_second_flag);
        chk("command", cmd, unavail_time_command);
        chk("combined", comb, unavail_time_combined);
        chk("bidir_flag", comb, bidir_unavail_second_flag);
        chk("bidir_events", be, bidir_events);
        chk("ptr_delayed", ptr_exp, pointer_justify_delayed);
        chk("quarter_count", acc, current_quarter_count);
        if (q) chk("history_count", hist, history_count);
    endtask : sec

    // Pulse tallies lag a clock behind the last second
    task automatic tally(input string nm);
        @(posedge clk);
        chk("unidir_report0", e_rep0, n_rep0);
        chk("unidir_report1", e_rep1, n_rep1);
        chk("bidir_report", e_brep, n_brep);
        chk("history_valid", e_hv, n_hv);
        $display("Test %s finished", nm);
    endtask : tally

    // Distinct values walk both delay lines in available time
    task automatic t_delay();
        for (int s = 0; s < 12; s++) begin
            sec(mk(16'hA5A5 ^ 16'(s), 1'b0, 1'b0), 16'h3C00 + 16'(s),
                1'b0);
        end
        tally("delay");
    endtask : t_delay

    // Nine severe seconds fall short; the next ten set, ten clear
    task automatic t_set();
        for (int s = 0; s < 34; s++) begin
            sec(mk(16'h0F00 + 16'(s), s != 9 && s < 22, 1'b0),
                16'(s), 1'b0);
        end
        tally("set");
    endtask : t_set

    // Clearing run broken by one severe second restarts the count
    task automatic t_clear();
        for (int s = 0; s < 52; s++) begin
            sec(mk(16'h1234 ^ 16'(s), 1'b0,
                (s >= 12 && s < 22) || s == 31), 16'(s), 1'b0);
        end
        tally("clear");
    endtask : t_clear

    // Absent inputs read as zero even when the source is severe
    task automatic t_conn();
        events_connected <= 6'h03;
        // Let the new mask settle before the reference reads it
        @(posedge clk);
        for (int s = 0; s < 12; s++) begin
            sec(mk(16'hFFFF, 1'b0, 1'b1), 16'h0000, 1'b0);
        end
        events_connected <= 6'h3F;
        tally("conn");
    endtask : t_conn

    // Quarter tick while unavailable hands the total over
    task automatic t_quarter();
        for (int s = 0; s < 24; s++) begin
            sec(mk(16'h00FF, 1'b1, 1'b0), 16'h0000, s == 21);
        end
        tally("quarter");
    endtask : t_quarter

    task automatic close_out();
        $display("Counts: %0d comparisons, %0d mismatches",
                 comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    // About 134 seconds of four clocks each; allow ample margin
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        events_connected = 6'h3F;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_delay();
        t_set();
        t_clear();
        t_conn();
        t_quarter();
        close_out();
    end
endmodule : tb
`default_nettype wire
